//--- design/dcg_regs.vh
// Constants for the daisy-chain group command handler
`ifndef DCG_REGS_VH
`define DCG_REGS_VH

// ----------------------------------------
// Frame initialization byte categories
// ----------------------------------------
`define DCG_CAT_SINGLE_RD 4'h8
`define DCG_CAT_SINGLE_WR 4'h9
`define DCG_CAT_STACK_RD 4'hA
`define DCG_CAT_STACK_WR 4'hB
`define DCG_CAT_BCAST_RD 4'hC
`define DCG_CAT_BCAST_WR 4'hD
`define DCG_CAT_BCAST_REV 4'hE

// ----------------------------------------
// Field positions and sizes
// ----------------------------------------
`define DCG_INIT_CAT_MSB 7
`define DCG_INIT_CAT_LSB 4
`define DCG_INIT_SIZE_MSB 2
`define DCG_INIT_SIZE_LSB 0
`define DCG_MAX_WR_BYTES 8
`define DCG_RESP_PROTO_BYTES 6
`define DCG_REG_ADDR_BYTES 2
`define DCG_CRC_BYTES 2

// ----------------------------------------
// CRC constants (reflected polynomial, init, good residue)
// ----------------------------------------
`define DCG_CRC_POLY 16'hA001
`define DCG_CRC_INIT 16'hFFFF
`define DCG_CRC_GOOD 16'h0000

`endif

//--- design/dcg_group_cmd.v
// Group command decoder, executor and chained response builder
`timescale 1ns/1ps
`include "dcg_regs.vh"

// Notes on behaviour
// - Stack read is init 0xA0, no device address, then two-byte start address.
// - Stack read and write are acted on only by stack members.
// - Each addressed device returns one frame of requested bytes plus six.
// - Read data byte holds requested byte count minus one.
// - Device N holds its response until frame from N+1 has arrived.
// - Upstream CRC checked on the fly; bad CRC withholds response, raises fault.
// - Stack write init is 0xB0 plus register count minus one.
// - Group writes update up to eight consecutive registers from start address.
// - Stack write frame: init, two address bytes, data, CRC; no device address.
// - Broadcast read 0xC0, no address; every device including base responds.
// - Broadcast write 0xD0 plus count minus one; applies to every device.
// - Reverse broadcast write 0xE0 to 0x0105 data 0x80 sets direction select.
// - Register address field is two bytes, giving first register touched.
// - Command frames with invalid CRC are never executed.
// - At most one response frame per command frame.
// - Response frame: init, own address, register address, data, CRC.
// - Response init byte holds returned data count minus one.
module dcg_group_cmd (
  input wire clk, // 25 MHz system clock
  input wire rst, // Synchronous reset, active high
  input wire isStackMember, // High when not base or bridge device
  input wire isTopOfStack, // High when no device sits above this one
  input wire [5:0] myAddress, // This device's chain address
  input wire cmdValid, // Command byte strobe
  input wire [7:0] cmdByte, // Command byte
  input wire upValid, // Upstream response byte strobe
  input wire [7:0] upByte, // Upstream response byte
  output reg regWrStb_reg, // Register write strobe
  output reg [15:0] regWrAddr_reg, // Register write address
  output reg [7:0] regWrData_reg, // Register write data
  output reg regRdReq_reg, // Register read request
  output reg [15:0] regRdAddr_reg, // Register read address
  input wire [7:0] regRdData, // Read data, valid cycle after request
  output wire txValid, // Own response byte valid
  output reg [7:0] txByte_reg, // Own response byte
  input wire txReady, // Response byte accepted
  output reg cmdCrcErr_reg, // Pulse: command frame CRC bad
  output reg upCrcErr_reg, // Pulse: upstream response CRC bad
  output wire busy // Handler not idle
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CMD = 3'd1;
  localparam [2:0] ST_WEXEC = 3'd2;
  localparam [2:0] ST_WAITUP = 3'd3;
  localparam [2:0] ST_RLOAD = 3'd4;
  localparam [2:0] ST_RWAIT = 3'd5;
  localparam [2:0] ST_RCAP = 3'd6;
  localparam [2:0] ST_RSEND = 3'd7;

  // ----------------------------------------
  // CRC over one byte, least significant bit first
  // ----------------------------------------
  function [15:0] crcByte;
    input [15:0] c;
    input [7:0] d;
    integer k;
    reg [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        x = x[0] ? ((x >> 1) ^ `DCG_CRC_POLY) : (x >> 1);
      end
      crcByte = x;
    end
  endfunction

  reg [2:0] state_reg;
  reg [3:0] cat_reg;
  reg [2:0] size_reg;
  reg [3:0] idx_reg;
  reg [3:0] frameLen_reg;
  reg [15:0] cmdCrc_reg;
  reg [15:0] startAddr_reg;
  reg [7:0] rdCount_reg;
  reg [63:0] wrData_reg;
  reg [2:0] wrIdx_reg;
  reg [7:0] upIdx_reg;
  reg [7:0] upLen_reg;
  reg [15:0] upCrc_reg;
  reg [7:0] respIdx_reg;
  reg [15:0] txCrc_reg;

  wire [3:0] inCat = cmdByte[`DCG_INIT_CAT_MSB:`DCG_INIT_CAT_LSB];
  wire [15:0] cmdCrcNext = crcByte(cmdCrc_reg, cmdByte);
  wire [15:0] upCrcNext = crcByte(upCrc_reg, upByte);
  wire hasAddrByte = (cat_reg == `DCG_CAT_SINGLE_RD) || (cat_reg == `DCG_CAT_SINGLE_WR);
  wire isRead = (cat_reg == `DCG_CAT_SINGLE_RD) || (cat_reg == `DCG_CAT_STACK_RD) ||
                (cat_reg == `DCG_CAT_BCAST_RD);
  // Base and bridge skip stack commands; single frames belong to another block
  wire isStackCmd = (cat_reg == `DCG_CAT_STACK_RD) || (cat_reg == `DCG_CAT_STACK_WR);
  wire forUs = !hasAddrByte && (!isStackCmd || isStackMember);
  // Body index counts bytes after the init byte and any device address
  wire [3:0] bodyIdx = idx_reg - {3'd0, hasAddrByte};
  wire lastCmdByte = cmdValid && (idx_reg == frameLen_reg);
  wire crcOk = (cmdCrcNext == `DCG_CRC_GOOD);
  wire [7:0] dataEnd = rdCount_reg + 8'd4;
  wire [7:0] respLast = rdCount_reg + 8'd5;
  wire txTake = txValid && txReady;

  assign txValid = (state_reg == ST_RSEND);
  assign busy = (state_reg != ST_IDLE);

  // ----------------------------------------
  // Command frame length from the init byte
  // ----------------------------------------
  // Index of the last byte: init(0), [addr], 2 address, data, 2 CRC
  function [3:0] lastIdx;
    input [3:0] cat;
    input [2:0] size;
    reg rd;
    reg ad;
    begin
      rd = (cat == `DCG_CAT_SINGLE_RD) || (cat == `DCG_CAT_STACK_RD) || (cat == `DCG_CAT_BCAST_RD);
      ad = (cat == `DCG_CAT_SINGLE_RD) || (cat == `DCG_CAT_SINGLE_WR);
      // Reads carry one count byte, writes size+1 data bytes
      lastIdx = 4'd4 + {3'd0, ad} + (rd ? 4'd0 : {1'b0, size}) + 4'd1;
    end
  endfunction

  // ----------------------------------------
  // Response byte selection
  // ----------------------------------------
  reg [7:0] respByte;
  always @* begin
    case (respIdx_reg)
      8'd0: respByte = rdCount_reg - 8'd1;
      8'd1: respByte = {2'b00, myAddress};
      8'd2: respByte = startAddr_reg[15:8];
      8'd3: respByte = startAddr_reg[7:0];
      default: respByte = (respIdx_reg == dataEnd) ? txCrc_reg[7:0] : txCrc_reg[15:8];
    endcase
  end

  // ----------------------------------------
  // Main control
  // ----------------------------------------
  // New command bytes are dropped while a frame is being executed or answered,
  // so a single command can never produce a second response.
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cat_reg <= 4'h0;
      size_reg <= 3'd0;
      idx_reg <= 4'd0;
      frameLen_reg <= 4'd0;
      cmdCrc_reg <= `DCG_CRC_INIT;
      startAddr_reg <= 16'h0000;
      rdCount_reg <= 8'h00;
      wrData_reg <= 64'h0000000000000000;
      wrIdx_reg <= 3'd0;
      upIdx_reg <= 8'h00;
      upLen_reg <= 8'h00;
      upCrc_reg <= `DCG_CRC_INIT;
      respIdx_reg <= 8'h00;
      txCrc_reg <= `DCG_CRC_INIT;
      txByte_reg <= 8'h00;
      regWrStb_reg <= 1'b0;
      regWrAddr_reg <= 16'h0000;
      regWrData_reg <= 8'h00;
      regRdReq_reg <= 1'b0;
      regRdAddr_reg <= 16'h0000;
      cmdCrcErr_reg <= 1'b0;
      upCrcErr_reg <= 1'b0;
    end else begin
      regWrStb_reg <= 1'b0;
      regRdReq_reg <= 1'b0;
      cmdCrcErr_reg <= 1'b0;
      upCrcErr_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // Only command categories start a frame; stray bytes are dropped
          if (cmdValid && cmdByte[7] && (inCat != 4'hF)) begin
            cat_reg <= inCat;
            size_reg <= cmdByte[`DCG_INIT_SIZE_MSB:`DCG_INIT_SIZE_LSB];
            frameLen_reg <= lastIdx(inCat, cmdByte[`DCG_INIT_SIZE_MSB:`DCG_INIT_SIZE_LSB]);
            cmdCrc_reg <= cmdCrcNext;
            idx_reg <= 4'd1;
            state_reg <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (cmdValid) begin
            cmdCrc_reg <= cmdCrcNext;
            idx_reg <= idx_reg + 4'd1;
            if (bodyIdx == 4'd1) begin
              startAddr_reg[15:8] <= cmdByte;
            end
            if (bodyIdx == 4'd2) begin
              startAddr_reg[7:0] <= cmdByte;
            end
            if (bodyIdx == 4'd3) begin
              rdCount_reg <= cmdByte + 8'd1;
            end
            // Write data is held until the CRC proves the frame good
            if ((bodyIdx >= 4'd3) && (bodyIdx < 4'd11)) begin
              wrData_reg[(bodyIdx - 4'd3) * 8 +: 8] <= cmdByte;
            end
            if (lastCmdByte) begin
              cmdCrc_reg <= `DCG_CRC_INIT;
              wrIdx_reg <= 3'd0;
              if (!crcOk) begin
                cmdCrcErr_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end else if (!forUs) begin
                state_reg <= ST_IDLE;
              end else if (!isRead) begin
                state_reg <= ST_WEXEC;
              end else if (isTopOfStack) begin
                respIdx_reg <= 8'd0;
                txCrc_reg <= `DCG_CRC_INIT;
                state_reg <= ST_RLOAD;
              end else begin
                upIdx_reg <= 8'd0;
                upCrc_reg <= `DCG_CRC_INIT;
                state_reg <= ST_WAITUP;
              end
            end
          end
        end
        ST_WEXEC: begin
          // One strobe per register; reverse broadcast write lands here too
          regWrStb_reg <= 1'b1;
          regWrAddr_reg <= startAddr_reg + {13'd0, wrIdx_reg};
          regWrData_reg <= wrData_reg[wrIdx_reg * 8 +: 8];
          wrIdx_reg <= wrIdx_reg + 3'd1;
          if (wrIdx_reg == size_reg) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WAITUP: begin
          // Upstream frame length comes from its own init byte
          if (upValid) begin
            upCrc_reg <= upCrcNext;
            upIdx_reg <= upIdx_reg + 8'd1;
            if (upIdx_reg == 8'd0) begin
              upLen_reg <= upByte + 8'd6;
            end
            if ((upIdx_reg != 8'd0) && (upIdx_reg == upLen_reg)) begin
              if (upCrcNext == `DCG_CRC_GOOD) begin
                respIdx_reg <= 8'd0;
                txCrc_reg <= `DCG_CRC_INIT;
                state_reg <= ST_RLOAD;
              end else begin
                upCrcErr_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        ST_RLOAD: begin
          // Data bytes come from the register file, the rest from the frame
          if ((respIdx_reg >= 8'd4) && (respIdx_reg < dataEnd)) begin
            regRdReq_reg <= 1'b1;
            regRdAddr_reg <= startAddr_reg + {8'd0, respIdx_reg - 8'd4};
            state_reg <= ST_RWAIT;
          end else begin
            txByte_reg <= respByte;
            state_reg <= ST_RSEND;
          end
        end
        ST_RWAIT: begin
          state_reg <= ST_RCAP;
        end
        ST_RCAP: begin
          txByte_reg <= regRdData;
          state_reg <= ST_RSEND;
        end
        ST_RSEND: begin
          if (txTake) begin
            // CRC bytes themselves are not folded into the running CRC
            if (respIdx_reg < dataEnd) begin
              txCrc_reg <= crcByte(txCrc_reg, txByte_reg);
            end
            respIdx_reg <= respIdx_reg + 8'd1;
            if (respIdx_reg == respLast) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_RLOAD;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // dcg_group_cmd

//--- verification/dcg_group_cmd_checker.sv
// Port-level checker for the group command handler
`timescale 1ns/1ps
module dcg_group_cmd_checker (
  input wire clk, // Clock
  input wire rst, // Sync reset
  input wire regWrStb_reg, // Write strobe
  input wire [15:0] regWrAddr_reg, // Write address
  input wire regRdReq_reg, // Read request
  input wire [7:0] regRdData, // Read data
  input wire txValid, // Byte offered
  input wire [7:0] txByte_reg, // Byte value
  input wire txReady, // Byte taken
  input wire cmdCrcErr_reg, // Command CRC fault
  input wire upCrcErr_reg, // Upstream CRC fault
  input wire busy // Not idle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Two strobes in a row walk one register up
  sequence two_writes;
    regWrStb_reg ##1 regWrStb_reg;
  endsequence
  // Read data is offered on the link two cycles after the request
  sequence read_to_tx;
    regRdReq_reg ##2 txValid;
  endsequence
  wr_addr_step_a: assert property (two_writes |-> regWrAddr_reg == $past(regWrAddr_reg) + 16'h0001)
    else $error("write address did not step by one");
  rd_data_path_a: assert property (regRdReq_reg |-> ##2 (txValid && txByte_reg == $past(regRdData)))
    else $error("read data not offered on time");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte_reg))
    else $error("offered byte not held");
  tx_one_take_a: assert property (txValid && txReady |=> !txValid)
    else $error("byte offered again after take");
  // Strobe is registered, so the last one lands after the handler is idle
  wr_busy_a: assert property (regWrStb_reg |-> $past(busy))
    else $error("write strobe while idle");
  bad_cmd_nowr_a: assert property (cmdCrcErr_reg |-> !regWrStb_reg [*6])
    else $error("write after bad command CRC");
  bad_up_notx_a: assert property (upCrcErr_reg |-> !txValid [*4])
    else $error("response after bad upstream CRC");
  err_pulse_a: assert property ((cmdCrcErr_reg || upCrcErr_reg) |=> !cmdCrcErr_reg && !upCrcErr_reg)
    else $error("fault pulse longer than a cycle");
  rd_tx_cov: cover property (read_to_tx);
endmodule // dcg_group_cmd_checker

bind dcg_group_cmd dcg_group_cmd_checker u_chk (.clk(clk), .rst(rst), .regWrStb_reg(regWrStb_reg),
  .regWrAddr_reg(regWrAddr_reg), .regRdReq_reg(regRdReq_reg), .regRdData(regRdData), .txValid(txValid),
  .txByte_reg(txByte_reg), .txReady(txReady), .cmdCrcErr_reg(cmdCrcErr_reg), .upCrcErr_reg(upCrcErr_reg),
  .busy(busy));

//--- verification/dcg_reg_model.sv
// Register bank model behind the handler's strobes
`timescale 1ns/1ps
module dcg_reg_model (
  input wire clk, // System clock
  input wire wrStb, // Write strobe
  input wire [15:0] wrAddr, // Write address
  input wire [7:0] wrData, // Write data
  input wire rdReq, // Read request
  input wire [15:0] rdAddr, // Read address
  output reg [7:0] rdData // Valid the cycle after a request
);
  reg [7:0] mem [0:1023];
  integer i;
  // Known contents so reads can be predicted
  initial begin
    rdData = 8'h00;
    for (i = 0; i < 1024; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
  end
  // One register per strobe
  always @(posedge clk) begin
    if (wrStb) mem[wrAddr[9:0]] <= wrData;
    // Data promised one cycle only, so scramble it otherwise
    rdData <= rdReq ? mem[rdAddr[9:0]] : ~rdData;
  end
endmodule // dcg_reg_model

//--- verification/test_daisy_chain_group_command_handler.sv
// Self-checking bench for the group command handler
`timescale 1ns/1ps
module test_daisy_chain_group_command_handler;
  reg clk, rst, isStackMember, isTopOfStack, cmdValid, upValid, txReady, sawCmdErr, sawUpErr;
  reg [5:0] myAddress;
  reg [7:0] cmdByte, upByte;
  wire regWrStb_reg, regRdReq_reg, txValid, cmdCrcErr_reg, upCrcErr_reg, busy;
  wire [15:0] regWrAddr_reg, regRdAddr_reg;
  wire [7:0] regWrData_reg, regRdData, txByte_reg;
  integer errors = 0, n_compared = 0;
  reg [7:0] fr[$], rx[$];
  dcg_group_cmd u_dut (.clk(clk), .rst(rst), .isStackMember(isStackMember), .isTopOfStack(isTopOfStack),
    .myAddress(myAddress), .cmdValid(cmdValid), .cmdByte(cmdByte), .upValid(upValid), .upByte(upByte),
    .regWrStb_reg(regWrStb_reg), .regWrAddr_reg(regWrAddr_reg), .regWrData_reg(regWrData_reg),
    .regRdReq_reg(regRdReq_reg), .regRdAddr_reg(regRdAddr_reg), .regRdData(regRdData), .txValid(txValid),
    .txByte_reg(txByte_reg), .txReady(txReady), .cmdCrcErr_reg(cmdCrcErr_reg), .upCrcErr_reg(upCrcErr_reg),
    .busy(busy));
  dcg_reg_model u_model (.clk(clk), .wrStb(regWrStb_reg), .wrAddr(regWrAddr_reg), .wrData(regWrData_reg),
    .rdReq(regRdReq_reg), .rdAddr(regRdAddr_reg), .rdData(regRdData));
  // ----------------------------------------
  // Clock, fault latches, watchdog
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmdCrcErr_reg === 1'b1) sawCmdErr <= 1;
    if (upCrcErr_reg === 1'b1) sawUpErr <= 1;
  end
  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #2000000;
    errors = errors + 1;
    end_sim;
  end
  task chk(input string what, input [15:0] exp, input [15:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function [15:0] crc(input reg [7:0] q[$]);
    integer i, k;
    reg [15:0] c;
    c = 16'hFFFF;
    for (i = 0; i < q.size(); i = i + 1) begin
      c = c ^ {8'h00, q[i]};
      for (k = 0; k < 8; k = k + 1) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  function [7:0] initVal(input [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  // Frame plus CRC, low byte first; bad flips the high CRC byte
  task send_cmd(input bad);
    reg [15:0] c;
    integer i;
    c = crc(fr);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8] ^ {8{bad}});
    sawCmdErr = 0;
    sawUpErr = 0;
    rx = {};
    for (i = 0; i < fr.size(); i = i + 1) begin
      @(posedge clk);
      #1 cmdValid = 1;
      cmdByte = fr[i];
    end
    @(posedge clk);
    #1 cmdValid = 0;
  endtask
  // Frame from the device above: two data bytes
  task send_up(input bad);
    integer i;
    chk("quiet before upstream", 0, txValid);
    fr = {8'h01, 8'h06, 8'h02, 8'h15, 8'h11, 8'h22};
    send_cmd_up(bad);
  endtask
  task send_cmd_up(input bad);
    reg [15:0] c;
    integer i;
    c = crc(fr);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8] ^ {8{bad}});
    for (i = 0; i < fr.size(); i = i + 1) begin
      @(posedge clk);
      #1 upValid = 1;
      upByte = fr[i];
      chk("quiet while upstream", 0, txValid);
    end
    @(posedge clk);
    #1 upValid = 0;
  endtask
  // Collect response with a far side that takes every other cycle
  task run;
    integer n;
    for (n = 0; n < 400 && !(n > 2 && busy === 1'b0); n = n + 1) begin
      // Sample mid-cycle, where the take of the coming edge is settled
      @(negedge clk);
      if (txValid === 1'b1 && txReady === 1'b1) rx.push_back(txByte_reg);
      @(posedge clk);
      #1 txReady = ~txReady;
    end
    // Last register strobe lands one edge after the handler goes idle
    @(posedge clk);
    #1;
    chk("idle", 0, busy);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_stack_wr;
    isStackMember = 1;
    fr = {8'hB3, 8'h01, 8'h00, 8'h02, 8'hB7, 8'h78, 8'hBC};
    send_cmd(0);
    run;
    chk("reg 100", 16'h02, u_model.mem[16'h100]);
    chk("reg 103", 16'hBC, u_model.mem[16'h103]);
    chk("reg 104", initVal(16'h104), u_model.mem[16'h104]);
  endtask
  task t_nonmember;
    isStackMember = 0;
    fr = {8'hB1, 8'h01, 8'h10, 8'hAA, 8'hBB};
    send_cmd(0);
    run;
    chk("ignored write", initVal(16'h110), u_model.mem[16'h110]);
    fr = {8'hA0, 8'h02, 8'h15, 8'h00};
    send_cmd(0);
    run;
    chk("ignored read", 0, rx.size());
    // Single-device frames are consumed but left to another block
    fr = {8'h91, 8'h05, 8'h01, 8'h40, 8'hCC, 8'hDD};
    send_cmd(0);
    run;
    chk("single frame skipped", initVal(16'h140), u_model.mem[16'h140]);
  endtask
  task t_bcast_wr;
    integer i;
    fr = {8'hD7, 8'h01, 8'h20, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
    send_cmd(0);
    run;
    for (i = 0; i < 8; i = i + 1) chk("bcast reg", 16'h10 + i, u_model.mem[16'h120 + i]);
    chk("bcast reg 128", initVal(16'h128), u_model.mem[16'h128]);
  endtask
  task t_reverse;
    fr = {8'hE0, 8'h01, 8'h05, 8'h80};
    send_cmd(0);
    run;
    chk("direction reg", 16'h80, u_model.mem[16'h105]);
  endtask
  task t_bad_crc;
    fr = {8'hD0, 8'h01, 8'h30, 8'h55};
    send_cmd(1);
    run;
    chk("cmd crc fault", 1, sawCmdErr);
    chk("not written", initVal(16'h130), u_model.mem[16'h130]);
  endtask
  task t_stack_rd_top;
    isStackMember = 1;
    isTopOfStack = 1;
    myAddress = 6'h05;
    fr = {8'hA0, 8'h02, 8'h15, 8'h01};
    send_cmd(0);
    run;
    chk("frame size", 8, rx.size());
    chk("resp count", 8'h01, rx[0]);
    chk("resp addr", 8'h05, rx[1]);
    chk("resp reg", 16'h0215, {rx[2], rx[3]});
    chk("resp data", initVal(16'h216), rx[5]);
    chk("resp crc", 0, crc(rx));
  endtask
  task t_bcast_rd_chain;
    isStackMember = 0;
    isTopOfStack = 0;
    fr = {8'hC0, 8'h02, 8'h15, 8'h00};
    send_cmd(0);
    send_up(0);
    run;
    chk("own frame", 7, rx.size());
    chk("own data", initVal(16'h215), rx[4]);
    fr = {8'hC0, 8'h02, 8'h15, 8'h00};
    send_cmd(0);
    send_up(1);
    run;
    chk("up crc fault", 1, sawUpErr);
    chk("withheld", 0, rx.size());
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1;
    isStackMember = 0;
    isTopOfStack = 1;
    myAddress = 6'h05;
    cmdValid = 0;
    cmdByte = 8'h00;
    upValid = 0;
    upByte = 8'h00;
    txReady = 1;
    repeat (5) @(posedge clk);
    #1 rst = 0;
    t_stack_wr;
    t_nonmember;
    t_bcast_wr;
    t_reverse;
    t_bad_crc;
    t_stack_rd_top;
    t_bcast_rd_chain;
    end_sim;
  end
endmodule // test_daisy_chain_group_command_handler
